// [design/cmc_consts.svh]
`ifndef CMC_CONSTS_SVH
`define CMC_CONSTS_SVH

// Clock rate and the times that are counted against it.
`define CMC_CLK_MHZ 200
`define CMC_SRC_QUAL_MS 32
`define CMC_MS_CYCLES (`CMC_CLK_MHZ * 1000)
`define CMC_MS_PER_MIN 60000
`define CMC_USB_TMR_SHORT_MIN 2
`define CMC_USB_TMR_LONG_MIN 45

// Widths of the counters and of the current figures.
`define CMC_MA_W 12
`define CMC_PRESCALE_W 18
`define CMC_QUAL_W 23
`define CMC_USB_W 22

// Current figures in mA.
`define CMC_SDP_HIGH_MA 12'h1f4
`define CMC_SDP_LOW_MA 12'h064
`define CMC_CDP_DCP_MA 12'h5dc
`define CMC_LINEAR_MA 12'h032
`define CMC_DFLT_SEC_MA 12'h3e8
`define CMC_DFLT_BUS_MA 12'h1f4
`define CMC_DFLT_PRE_MA 12'h1c2
`define CMC_DFLT_FAST_MA 12'h3e8

`endif

// [design/cmc_pkg.sv]
package cmc_pkg;

    typedef enum logic [3:0] {
        ST_OFF,
        ST_DETECT,
        ST_VALIDATE,
        ST_SDP_STANDBY,
        ST_DIS_HOLD,
        ST_LINEAR,
        ST_PRE,
        ST_FAST,
        ST_LOCKOUT
    } cmc_state_t;

    typedef enum logic [1:0] {
        AD_SDP,
        AD_CDP,
        AD_DCP,
        AD_UNKNOWN
    } cmc_adapter_t;

    typedef enum logic [1:0] {
        SW_OFF,
        SW_LINEAR,
        SW_FULL
    } cmc_switch_t;

endpackage

// [design/cmc_sync.sv]
`timescale 1ns/100ps
`default_nettype none

module cmc_sync #(
    parameter int W = 3
) (
    // Clock, reset and enable.
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Raw and synchronised levels.
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_reg;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            meta_reg <= '0;
            q <= '0;
        end else if (clk_en) begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule

`default_nettype wire

// [design/cmc_timer.sv]
`timescale 1ns/100ps
`default_nettype none

module cmc_timer #(
    parameter int W = 16
) (
    // Clock, reset and enable.
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Control.
    input wire logic clear,
    input wire logic tick,
    input wire logic [W-1:0] limit,
    // Status.
    output logic expired
);

    logic [W-1:0] count_reg;

    // Expiry is sticky until clear, so a late tick cannot wrap the count.
    always_ff @(posedge mclk) begin
        if (sys_rst || (clk_en && clear)) begin
            count_reg <= '0;
            expired <= 1'b0;
        end else if (clk_en && tick && !expired) begin
            count_reg <= count_reg + 1'b1;
            expired <= (count_reg + 1'b1) >= limit;
        end
    end

endmodule

`default_nettype wire

// [design/cmc_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "cmc_consts.svh"

// What this block does
// - After validation, load register defaults if battery is below minimum.
// - Bus limit field is ignored until Host Control begins.
// - Host Control begins with the first write while charging, in SDP Standby or in the disable hold.
// - With detection, unidentified adapters are treated as SDP Auto-Charge.
// - SDP Auto-Charge runs the USB timer; expiry locks into Standby.
// - SDP with good battery disables LDO, Standby until any write.
// - SDP with disable pin high keeps LDO off until pin low or host.
// - CDP or DCP Auto-Charge uses safety timer and 1500 mA bus limit.
// - Without detection, limit-select pin picks limit; safety timer used.
// - Battery below short at start: 50 mA linear, default system voltage.
// - Pre-charge when starting between thresholds or rising past short.
// - Pre-charge uses precharge field, system-voltage field, rail floor.
// - All register writes are accepted during pre-charge.
// - Fast charge when starting above minimum or rising past minimum.
// - Fast charge: switch fully on, fast-charge field, CC until float.
// - Host Control defaults, charging flag and power-good flag behaviour.
// - Adapter detection starts after bus stays above rise for 32 ms.
module cmc_top #(
    parameter bit HAS_DETECT = 1'b1,
    parameter bit SDP_LOW_VARIANT = 1'b0,
    parameter int SRC_QUAL_CYCLES = `CMC_SRC_QUAL_MS * `CMC_MS_CYCLES,
    parameter int MS_CYCLES = `CMC_MS_CYCLES
) (
    // Clock, reset and enable.
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Source status from the power front end.
    input wire logic src_present,
    input wire logic bus_above_rise,
    input wire logic src_validated,
    // Adapter detection handshake.
    output logic det_start,
    input wire logic det_done,
    input wire logic [1:0] det_type,
    // Pins.
    input wire logic limit_select_pin,
    input wire logic disable_pin,
    // Battery comparators, not yet synchronised.
    input wire logic bat_above_short,
    input wire logic bat_above_min,
    input wire logic bat_above_good,
    input wire logic bat_at_float,
    input wire logic top_off_active,
    // Register interface events.
    input wire logic host_write,
    output logic reg_restore,
    output logic regs_writable,
    // Current-limit selection.
    output logic host_control,
    output logic use_bus_limit_field,
    output logic [`CMC_MA_W-1:0] auto_bus_limit_ma,
    output logic [`CMC_MA_W-1:0] dflt_sec_limit_ma,
    output logic [`CMC_MA_W-1:0] dflt_bus_limit_ma,
    output logic [`CMC_MA_W-1:0] dflt_precharge_ma,
    output logic [`CMC_MA_W-1:0] dflt_fast_charge_ma,
    // Timer selection.
    output logic usb_timer_active,
    output logic safety_timer_active,
    // Power path control.
    output logic ldo_enable,
    output logic [1:0] switch_mode,
    output logic [`CMC_MA_W-1:0] linear_limit_ma,
    output logic use_precharge_current,
    output logic use_fast_charge_current,
    output logic sys_v_use_default,
    output logic sys_floor_at_min,
    output logic cc_active,
    // Status flags.
    output logic standby,
    output logic charging_flag,
    output logic power_good_flag
);

    localparam logic [`CMC_USB_W-1:0] USB_LIMIT_MS = SDP_LOW_VARIANT ?
        `CMC_USB_W'(`CMC_USB_TMR_LONG_MIN * `CMC_MS_PER_MIN) :
        `CMC_USB_W'(`CMC_USB_TMR_SHORT_MIN * `CMC_MS_PER_MIN);
    localparam logic [`CMC_MA_W-1:0] SDP_MA = SDP_LOW_VARIANT ?
        `CMC_SDP_LOW_MA : `CMC_SDP_HIGH_MA;
    localparam logic [`CMC_PRESCALE_W-1:0] MS_LAST =
        `CMC_PRESCALE_W'(MS_CYCLES - 1);
    localparam logic [`CMC_QUAL_W-1:0] QUAL_LIMIT =
        `CMC_QUAL_W'(SRC_QUAL_CYCLES);

    // Picks the charge phase from the battery level when charging begins.
    function automatic cmc_pkg::cmc_state_t start_phase(
        input logic above_short,
        input logic above_min
    );
        if (!above_short) begin
            return cmc_pkg::ST_LINEAR;
        end else if (!above_min) begin
            return cmc_pkg::ST_PRE;
        end
        return cmc_pkg::ST_FAST;
    endfunction

    cmc_pkg::cmc_state_t state_reg;
    cmc_pkg::cmc_state_t state_next;
    cmc_pkg::cmc_adapter_t adapter_reg;
    cmc_pkg::cmc_adapter_t adapter_next;
    logic host_reg;
    logic host_next;
    logic restore_reg;
    logic restore_next;
    logic [`CMC_MA_W-1:0] limit_reg;
    logic [`CMC_MA_W-1:0] limit_next;
    logic pgood_reg;
    logic [`CMC_PRESCALE_W-1:0] presc_reg;
    logic ms_tick;
    logic [3:0] cmp_sync;
    logic bat_short_s;
    logic bat_min_s;
    logic bat_good_s;
    logic bat_float_s;
    logic qual_done;
    logic usb_expired;
    logic in_charge;
    logic sdp_auto;
    logic usb_run;

    // Comparators toggle with ripple near a threshold; only the second
    // flop of each synchroniser feeds the state machine.
    cmc_sync #(
        .W(4)
    ) u_cmp_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .d({bat_at_float, bat_above_good, bat_above_min, bat_above_short}),
        .q(cmp_sync)
    );

    assign bat_short_s = cmp_sync[0];
    assign bat_min_s = cmp_sync[1];
    assign bat_good_s = cmp_sync[2];
    assign bat_float_s = cmp_sync[3];

    // Qualification restarts whenever the bus dips below its rising level.
    cmc_timer #(
        .W(`CMC_QUAL_W)
    ) u_qual_timer (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .clear(!bus_above_rise || !src_present),
        .tick(1'b1),
        .limit(QUAL_LIMIT),
        .expired(qual_done)
    );

    // Millisecond prescaler keeps the minute-scale timer narrow.
    assign ms_tick = (presc_reg == MS_LAST);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            presc_reg <= '0;
        end else if (clk_en) begin
            presc_reg <= ms_tick ? '0 : presc_reg + 1'b1;
        end
    end

    assign in_charge = (state_reg == cmc_pkg::ST_LINEAR) ||
                       (state_reg == cmc_pkg::ST_PRE) ||
                       (state_reg == cmc_pkg::ST_FAST);
    assign sdp_auto = HAS_DETECT && !host_reg &&
                      (adapter_reg == cmc_pkg::AD_SDP);
    assign usb_run = in_charge && sdp_auto;

    // The USB timer is cleared whenever SDP Auto-Charge is not in force,
    // so Host Control stops it at once.
    cmc_timer #(
        .W(`CMC_USB_W)
    ) u_usb_timer (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .clear(!usb_run),
        .tick(ms_tick),
        .limit(USB_LIMIT_MS),
        .expired(usb_expired)
    );

    always_comb begin
        state_next = state_reg;
        adapter_next = adapter_reg;
        host_next = host_reg;
        restore_next = 1'b0;
        limit_next = limit_reg;
        unique case (state_reg)
            cmc_pkg::ST_OFF: begin
                if (qual_done) begin
                    state_next = HAS_DETECT ? cmc_pkg::ST_DETECT :
                                              cmc_pkg::ST_VALIDATE;
                end
            end
            cmc_pkg::ST_DETECT: begin
                if (det_done) begin
                    // Anything not a charging port is handled as SDP.
                    if (det_type == cmc_pkg::AD_CDP ||
                        det_type == cmc_pkg::AD_DCP) begin
                        adapter_next = cmc_pkg::cmc_adapter_t'(det_type);
                        limit_next = `CMC_CDP_DCP_MA;
                    end else begin
                        adapter_next = cmc_pkg::AD_SDP;
                        limit_next = SDP_MA;
                    end
                    state_next = cmc_pkg::ST_VALIDATE;
                end
            end
            cmc_pkg::ST_VALIDATE: begin
                if (src_validated) begin
                    restore_next = !bat_min_s;
                    if (!HAS_DETECT) begin
                        limit_next = limit_select_pin ? SDP_MA :
                                     `CMC_CDP_DCP_MA;
                    end
                    if (HAS_DETECT && adapter_reg == cmc_pkg::AD_SDP &&
                        bat_good_s) begin
                        state_next = cmc_pkg::ST_SDP_STANDBY;
                    end else if (HAS_DETECT &&
                                 adapter_reg == cmc_pkg::AD_SDP &&
                                 disable_pin) begin
                        state_next = cmc_pkg::ST_DIS_HOLD;
                    end else begin
                        state_next = start_phase(bat_short_s, bat_min_s);
                    end
                end
            end
            cmc_pkg::ST_SDP_STANDBY: begin
                if (host_write) begin
                    host_next = 1'b1;
                    state_next = start_phase(bat_short_s, bat_min_s);
                end
            end
            cmc_pkg::ST_DIS_HOLD: begin
                if (host_write) begin
                    host_next = 1'b1;
                    state_next = start_phase(bat_short_s, bat_min_s);
                end else if (!disable_pin) begin
                    state_next = start_phase(bat_short_s, bat_min_s);
                end
            end
            cmc_pkg::ST_LINEAR: begin
                if (bat_short_s) begin
                    state_next = cmc_pkg::ST_PRE;
                end
            end
            cmc_pkg::ST_PRE: begin
                if (bat_min_s) begin
                    state_next = cmc_pkg::ST_FAST;
                end
            end
            cmc_pkg::ST_FAST: begin
            end
            cmc_pkg::ST_LOCKOUT: begin
            end
        endcase
        // The first write that lands while charging hands over control.
        if (in_charge && host_write) begin
            host_next = 1'b1;
        end
        if (usb_expired && usb_run && !host_write) begin
            state_next = cmc_pkg::ST_LOCKOUT;
        end
        // Only a removal and replug leaves the lockout.
        if (!src_present) begin
            state_next = cmc_pkg::ST_OFF;
            host_next = 1'b0;
            adapter_next = cmc_pkg::AD_SDP;
            limit_next = SDP_MA;
            restore_next = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg <= cmc_pkg::ST_OFF;
            adapter_reg <= cmc_pkg::AD_SDP;
            host_reg <= 1'b0;
            restore_reg <= 1'b0;
            limit_reg <= SDP_MA;
            pgood_reg <= 1'b0;
        end else if (clk_en) begin
            state_reg <= state_next;
            adapter_reg <= adapter_next;
            host_reg <= host_next;
            restore_reg <= restore_next;
            limit_reg <= limit_next;
            pgood_reg <= bat_good_s;
        end
    end

    // Detection is requested once, on the cycle qualification completes.
    assign det_start = HAS_DETECT && (state_reg == cmc_pkg::ST_OFF) &&
                       qual_done && src_present;

    assign reg_restore = restore_reg;
    assign regs_writable = 1'b1;
    assign host_control = host_reg;
    assign use_bus_limit_field = host_reg;
    assign auto_bus_limit_ma = limit_reg;

    assign dflt_sec_limit_ma = `CMC_DFLT_SEC_MA;
    assign dflt_bus_limit_ma = `CMC_DFLT_BUS_MA;
    assign dflt_precharge_ma = `CMC_DFLT_PRE_MA;
    assign dflt_fast_charge_ma = `CMC_DFLT_FAST_MA;

    assign usb_timer_active = usb_run;
    assign safety_timer_active = in_charge && !usb_run;

    assign ldo_enable = src_present &&
                        (state_reg != cmc_pkg::ST_SDP_STANDBY) &&
                        (state_reg != cmc_pkg::ST_DIS_HOLD);

    // Linear and pre-charge both run the switch as a current source.
    assign switch_mode = (state_reg == cmc_pkg::ST_FAST) ?
                         2'(cmc_pkg::SW_FULL) :
                         (state_reg == cmc_pkg::ST_LINEAR ||
                          state_reg == cmc_pkg::ST_PRE) ?
                         2'(cmc_pkg::SW_LINEAR) :
                         2'(cmc_pkg::SW_OFF);
    assign linear_limit_ma = (state_reg == cmc_pkg::ST_LINEAR) ?
                             `CMC_LINEAR_MA : '0;
    assign use_precharge_current = (state_reg == cmc_pkg::ST_PRE);
    assign use_fast_charge_current = (state_reg == cmc_pkg::ST_FAST);
    assign sys_v_use_default = (state_reg == cmc_pkg::ST_LINEAR);
    assign sys_floor_at_min = (state_reg == cmc_pkg::ST_PRE);
    assign cc_active = (state_reg == cmc_pkg::ST_FAST) && !bat_float_s;

    assign standby = (state_reg == cmc_pkg::ST_SDP_STANDBY) ||
                     (state_reg == cmc_pkg::ST_LOCKOUT);
    assign charging_flag = in_charge && !top_off_active;
    assign power_good_flag = pgood_reg;

endmodule

`default_nettype wire

// [tb/cmc_adapter_model.sv]
`timescale 1ns/100ps
`default_nettype none

module cmc_adapter_model (
    // Clock.
    input wire logic mclk,
    // Detection handshake and the adapter that is plugged in.
    input wire logic det_start,
    input wire logic [1:0] kind,
    output logic det_done = 1'b0,
    output logic [1:0] det_type = 2'h0
);
    logic [2:0] dly = 3'h0;

    // Outside its one valid cycle the type lines carry the inverse, so a
    // design that samples them late reads a wrong adapter.
    always @(posedge mclk) begin
        dly <= {dly[1:0], det_start === 1'b1};
        det_done <= dly[2];
        det_type <= dly[2] ? kind : ~kind;
    end
endmodule
`default_nettype wire

// [tb/cmc_top_sva.sv]
`timescale 1ns/100ps
`default_nettype none
`include "cmc_consts.svh"

module cmc_top_sva #(
    parameter bit SDP_LOW_VARIANT = 1'b0,
    parameter int SRC_QUAL_CYCLES = 20
) (
    // Clock, reset and enable.
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Inputs.
    input wire logic src_present,
    input wire logic bus_above_rise,
    input wire logic det_done,
    input wire logic [1:0] det_type,
    input wire logic bat_above_good,
    input wire logic top_off_active,
    input wire logic host_write,
    // Outputs.
    input wire logic det_start,
    input wire logic reg_restore,
    input wire logic host_control,
    input wire logic use_bus_limit_field,
    input wire logic [`CMC_MA_W-1:0] auto_bus_limit_ma,
    input wire logic usb_timer_active,
    input wire logic ldo_enable,
    input wire logic [1:0] switch_mode,
    input wire logic [`CMC_MA_W-1:0] linear_limit_ma,
    input wire logic use_precharge_current,
    input wire logic use_fast_charge_current,
    input wire logic sys_v_use_default,
    input wire logic sys_floor_at_min,
    input wire logic standby,
    input wire logic charging_flag,
    input wire logic power_good_flag
);
    localparam logic [11:0] SDP_MA = SDP_LOW_VARIANT ? 12'h064 : 12'h1f4;
    int qual_cnt;
    logic [1:0] up_cnt;
    wire in_charge = use_fast_charge_current || use_precharge_current ||
        sys_v_use_default;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    always_ff @(posedge mclk) begin
        if (sys_rst || !(bus_above_rise && src_present)) qual_cnt <= 0;
        else if (clk_en) qual_cnt <= qual_cnt + 1;
    end

    // The comparator pipe holds reset values for three edges after release.
    always_ff @(posedge mclk) begin
        if (sys_rst || !clk_en) up_cnt <= 2'h0;
        else if (up_cnt != 2'h3) up_cnt <= up_cnt + 2'h1;
    end

    sequence s_cdp_answer;
        det_start ##[1:8] (det_done && (det_type == 2'h1 || det_type == 2'h2));
    endsequence
    sequence s_sdp_answer;
        det_start ##[1:8] (det_done && (det_type == 2'h0 || det_type == 2'h3));
    endsequence

    a_restore_one_shot: assert property (reg_restore |=> !reg_restore)
        else $error("restore pulse too long");
    a_bus_field_gate: assert property (
        use_bus_limit_field == host_control and
        ($rose(host_control) |-> $past(host_write)))
        else $error("bus limit field gate wrong");
    a_write_takes_host: assert property (
        host_write && in_charge && src_present |=> host_control)
        else $error("write did not establish host control");
    a_cdp_dcp_limit: assert property (
        s_cdp_answer |=> auto_bus_limit_ma == 12'h5dc)
        else $error("charging port limit wrong");
    a_sdp_limit: assert property (
        s_sdp_answer |=> auto_bus_limit_ma == SDP_MA)
        else $error("standard port limit wrong");
    a_usb_auto_only: assert property (usb_timer_active |-> !host_control)
        else $error("usb timer under host control");
    a_ldo_in_charge: assert property (
        in_charge && src_present |-> ldo_enable && !standby)
        else $error("ldo off while charging");
    a_linear_setup: assert property (
        sys_v_use_default |-> switch_mode == 2'h1 && linear_limit_ma == 12'h032)
        else $error("linear mode setup wrong");
    a_pre_setup: assert property (
        use_precharge_current |-> sys_floor_at_min && switch_mode == 2'h1)
        else $error("pre-charge setup wrong");
    a_fast_setup: assert property (
        use_fast_charge_current |->
        switch_mode == 2'h2 && !use_precharge_current)
        else $error("fast charge setup wrong");
    a_charge_flag: assert property (
        charging_flag == (in_charge && !top_off_active))
        else $error("charging flag wrong");
    a_qual_time: assert property (
        det_start |-> qual_cnt >= SRC_QUAL_CYCLES - 1 &&
        qual_cnt <= SRC_QUAL_CYCLES)
        else $error("detection started at wrong time");
    a_good_latency: assert property (
        up_cnt == 2'h3 |-> power_good_flag == $past(bat_above_good, 3))
        else $error("good flag latency wrong");
endmodule

bind cmc_top cmc_top_sva #(
    .SDP_LOW_VARIANT(SDP_LOW_VARIANT),
    .SRC_QUAL_CYCLES(SRC_QUAL_CYCLES)
) chk_i (
    .mclk, .sys_rst, .clk_en, .src_present, .bus_above_rise, .det_done,
    .det_type, .bat_above_good, .top_off_active, .host_write, .det_start,
    .reg_restore, .host_control, .use_bus_limit_field, .auto_bus_limit_ma,
    .usb_timer_active, .ldo_enable, .switch_mode, .linear_limit_ma,
    .use_precharge_current, .use_fast_charge_current, .sys_v_use_default,
    .sys_floor_at_min, .standby, .charging_flag, .power_good_flag
);
`default_nettype wire

// [tb/test_charge_mode_controller.sv]
`timescale 1ns/100ps
`default_nettype none

module test_charge_mode_controller;
    typedef struct packed {
        logic [1:0] k;
        logic s, m, g, d;
        logic [11:0] lim;
        logic [1:0] sw;
        logic usb, saf, ldo, sb, rs;
    } cmc_row_t;
    // Adapter, short/min/good/disable, then limit, phase, timers, ldo,
    // standby and restore; x marks a value the test does not check.
    localparam cmc_row_t ROWS [6] = '{
        '{2'h1, '1, '1, '0, '0, 12'h5dc, 2'h2, '0, '1, '1, '0, '0},
        '{2'h2, '0, '0, '0, '0, 12'h5dc, 2'h1, '0, '1, '1, '0, '1},
        '{2'h0, '1, '0, '0, '0, 12'h1f4, 2'h1, '1, '0, '1, '0, '1},
        '{2'h3, '1, '1, '0, '0, 12'h1f4, 2'h2, '1, '0, '1, '0, '0},
        '{2'h0, '1, '1, '1, '0, 12'h1f4, 2'bxx, 1'bx, 1'bx, '0, '1, '0},
        '{2'h0, '1, '1, '0, '1, 12'h1f4, 2'bxx, 1'bx, 1'bx, '0, '0, '0}};
    logic mclk = 1'b0;
    logic clk_en = 1'b1;
    logic sys_rst = 1'b1;
    logic src_present = 1'b0;
    logic bus_above_rise = 1'b0;
    logic src_validated = 1'b0;
    logic disable_pin = 1'b0;
    logic bat_above_short = 1'b0;
    logic bat_above_min = 1'b0;
    logic bat_above_good = 1'b0;
    logic bat_at_float = 1'b0;
    logic top_off_active = 1'b0;
    logic host_write = 1'b0;
    logic [1:0] kind = 2'h0;
    logic det_start, det_done, reg_restore, regs_writable, host_control;
    logic use_bus_limit_field, usb_timer_active, safety_timer_active;
    logic ldo_enable, use_precharge_current, use_fast_charge_current;
    logic sys_v_use_default, sys_floor_at_min, cc_active, standby;
    logic charging_flag, power_good_flag;
    logic [1:0] det_type, switch_mode;
    logic [11:0] auto_bus_limit_ma, dflt_sec_limit_ma, dflt_bus_limit_ma;
    logic [11:0] dflt_precharge_ma, dflt_fast_charge_ma, linear_limit_ma;
    int err_count = 0;
    int check_count = 0;
    int restore_cnt = 0;
    int r0;
    cmc_row_t r;

    always #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        if (reg_restore === 1'b1) restore_cnt <= restore_cnt + 1;
    end

    cmc_top #(.SRC_QUAL_CYCLES(20), .MS_CYCLES(2)) uut (
        .mclk, .sys_rst, .clk_en, .src_present, .bus_above_rise,
        .src_validated, .det_start, .det_done, .det_type,
        .limit_select_pin(1'b0), .disable_pin, .bat_above_short,
        .bat_above_min, .bat_above_good, .bat_at_float, .top_off_active,
        .host_write, .reg_restore, .regs_writable, .host_control,
        .use_bus_limit_field, .auto_bus_limit_ma, .dflt_sec_limit_ma,
        .dflt_bus_limit_ma, .dflt_precharge_ma, .dflt_fast_charge_ma,
        .usb_timer_active, .safety_timer_active, .ldo_enable, .switch_mode,
        .linear_limit_ma, .use_precharge_current, .use_fast_charge_current,
        .sys_v_use_default, .sys_floor_at_min, .cc_active, .standby,
        .charging_flag, .power_good_flag);
    cmc_adapter_model peer (.mclk, .det_start, .kind, .det_done, .det_type);

    task cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task chk(input logic [11:0] got, input logic [11:0] exp,
             input string what);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s", $time, what);
        end
    endtask
    task pulse_write;
        host_write = 1'b1;
        cyc(1);
        host_write = 1'b0;
    endtask
    // Comparators settle long before validation, so the phase is decided
    // on steady levels rather than on a crossing.
    task plug(input logic [1:0] k, input logic s, m, g, d);
        kind = k;
        bat_above_short = s;
        bat_above_min = m;
        bat_above_good = g;
        disable_pin = d;
        r0 = restore_cnt;
        src_present = 1'b1;
        bus_above_rise = 1'b1;
        for (int j = 0; j < 60 && det_start !== 1'b1; j++) cyc(1);
        cyc(10);
        src_validated = 1'b1;
        cyc(4);
        src_validated = 1'b0;
        cyc(4);
    endtask
    task unplug;
        src_present = 1'b0;
        bus_above_rise = 1'b0;
        cyc(3);
    endtask
    task finish_test;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        #20000;
        err_count++;
        finish_test();
    end

    initial begin
        cyc(12);
        sys_rst = 1'b0;
        chk(auto_bus_limit_ma, 12'h1f4, "reset limit");
        chk(regs_writable, 1'b1, "writable");
        for (int i = 0; i < 6; i++) begin
            r = ROWS[i];
            plug(r.k, r.s, r.m, r.g, r.d);
            chk(auto_bus_limit_ma, r.lim, "limit");
            if (r.sw !== 2'bxx) chk(switch_mode, r.sw, "phase");
            if (r.usb !== 1'bx) chk(usb_timer_active, r.usb, "usb timer");
            if (r.saf !== 1'bx) chk(safety_timer_active, r.saf, "saf");
            chk(ldo_enable, r.ldo, "ldo");
            chk(standby, r.sb, "standby");
            chk(12'(restore_cnt - r0), r.rs, "restore");
            unplug();
        end
        src_present = 1'b1;
        bus_above_rise = 1'b1;
        cyc(3);
        pulse_write();
        chk(host_control, 1'b0, "early write");
        plug(2'h0, '1, '0, '0, '0);
        pulse_write();
        chk(host_control, 1'b1, "host");
        chk(use_bus_limit_field, 1'b1, "bus field");
        chk(usb_timer_active, 1'b0, "usb off");
        chk(dflt_sec_limit_ma, 12'h3e8, "sec");
        chk(dflt_bus_limit_ma, 12'h1f4, "bus");
        chk(dflt_precharge_ma, 12'h1c2, "pre");
        chk(dflt_fast_charge_ma, 12'h3e8, "fast");
        bat_above_min = 1'b1;
        bat_above_good = 1'b1;
        cyc(4);
        chk(use_fast_charge_current, 1'b1, "to fast");
        chk(cc_active, 1'b1, "cc");
        chk(power_good_flag, 1'b1, "good");
        bat_at_float = 1'b1;
        cyc(3);
        chk(cc_active, 1'b0, "float");
        bat_at_float = 1'b0;
        top_off_active = 1'b1;
        cyc(1);
        chk(charging_flag, 1'b0, "top-off");
        top_off_active = 1'b0;
        unplug();
        chk(host_control, 1'b0, "unplug");
        plug(2'h0, '1, '1, '1, '0);
        pulse_write();
        cyc(2);
        chk(host_control, 1'b1, "standby write");
        chk(standby, 1'b0, "wake");
        chk(ldo_enable, 1'b1, "ldo back");
        unplug();
        plug(2'h0, '1, '1, '0, '1);
        disable_pin = 1'b0;
        cyc(3);
        chk(ldo_enable, 1'b1, "pin low ldo");
        chk(usb_timer_active, 1'b1, "sdp start");
        unplug();
        plug(2'h2, '0, '0, '0, '0);
        chk(linear_limit_ma, 12'h032, "linear");
        chk(sys_v_use_default, 1'b1, "system_voltage_setting");
        clk_en = 1'b0;
        bat_above_short = 1'b1;
        cyc(4);
        chk(sys_v_use_default, 1'b1, "frozen");
        clk_en = 1'b1;
        cyc(4);
        chk(use_precharge_current, 1'b1, "to pre");
        chk(sys_floor_at_min, 1'b1, "floor");
        chk(regs_writable, 1'b1, "pre writes");
        unplug();
        plug(2'h1, '1, '1, '0, '0);
        sys_rst = 1'b1;
        cyc(2);
        chk(switch_mode, 2'h0, "rst phase");
        chk(auto_bus_limit_ma, 12'h1f4, "rst limit");
        sys_rst = 1'b0;
        unplug();
        finish_test();
    end
endmodule
`default_nettype wire
